// ===== crvs_sequencer.sv
`timescale 1ns/10ps
module crvs_sequencer
	import crvs_pkg::*;
(
	input wire logic sys_clk_in, // 250 MHz clock
	input wire logic sys_rst_in, // Async reset, high
	input wire logic system_power_good_in, // Other rails good, async pin
	input wire logic [VID_W-1:0] vid_code_inputs, // VID code from processor, async
	input wire logic shutdown_pin_n_in, // Enable pin, low shuts down, async
	input wire logic uvlo_in, // Undervoltage lockout, async
	input wire logic thermal_shutdown_pin_n_in, // Thermal shutdown, async
	input wire logic overvoltage_in, // Output overvoltage fault, async
	input wire logic zero_cross_in, // Inductor zero crossing, async
	input wire logic phase3_strap_off_in, // Phase 3 strapped off, async
	input wire logic reduced_phases_in, // Running fewer phases, async
	input wire logic [1:0] pwm_req_in, // Modulator on-time request per phase
	input wire logic phase3_pwm_out_req_in, // Modulator request for phase 3
	output logic cpu_clock_enable_n_out, // Clock enable, low enables
	output logic output_power_good_out, // Output power-good
	output logic [VID_W-1:0] dac_level_out, // Present output target
	output logic skip_mode_out, // Skip mode active
	output crvs_drive_t drive_out, // Gate and PWM drives
	output logic boost_switch1_out, // Phase 1 boost switch closed
	output logic discharge_on_out // Output discharge transistor on
);
	// ====================================================
	// Helper functions

	// Level moved one step closer to the goal
	function automatic logic [VID_W-1:0] step_toward(input logic [VID_W-1:0] level,
		input logic [VID_W-1:0] goal);
		logic [VID_W-1:0] result;
		result = level;
		if (level < goal) begin
			result = level + 7'h01;
		end else if (level > goal) begin
			result = level - 7'h01;
		end
		return result;
	endfunction : step_toward

	// High-side gate level of one phase
	function automatic logic high_side_level(input logic shut_now, input logic hs_req);
		logic result;
		result = 1'b0;
		if (!shut_now) begin
			result = hs_req;
		end
		return result;
	endfunction : high_side_level

	// Low-side gate level of one phase, shutdown wins, then overvoltage over the rest
	function automatic logic low_side_level(input logic shut_now, input logic ov_now,
		input logic hs_req, input logic skip_now, input logic zc_now);
		logic result;
		result = !hs_req;
		if (shut_now) begin
			result = 1'b0;
		end else if (ov_now) begin
			result = 1'b1;
		end else if (skip_now && zc_now) begin
			result = 1'b0;
		end
		return result;
	endfunction : low_side_level

	// Step spacing in cycles for a state
	function automatic logic [7:0] slew_spacing(input crvs_state_t st);
		logic [7:0] result;
		result = SLEW_DIV_NORMAL;
		if (st == CRVS_FALLBACK) begin
			result = SLEW_DIV_QUARTER;
		end
		return result;
	endfunction : slew_spacing

	// ====================================================
	// Input synchronisers
	logic pgood_meta_reg;
	logic pgood_sync_reg;
	logic en_meta_reg;
	logic en_sync_reg;
	logic [1:0] fault_meta_reg;
	logic [1:0] fault_sync_reg;
	logic [1:0] prot_meta_reg;
	logic [1:0] prot_sync_reg;
	logic [1:0] strap_meta_reg;
	logic [1:0] strap_sync_reg;
	logic [VID_W-1:0] vid_meta_reg;
	logic [VID_W-1:0] vid_reg;
	logic pgood_s;
	logic en_s;
	logic uvlo_s;
	logic therm_s;
	logic ov_s;
	logic zc_s;
	logic strap_s;
	logic redph_s;

	// System power-good, two flops
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pgood_meta_reg <= 1'b0;
			pgood_sync_reg <= 1'b0;
		end else begin
			pgood_meta_reg <= system_power_good_in;
			pgood_sync_reg <= pgood_meta_reg;
		end
	end

	// Shutdown pin, two flops, resets as shut down
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			en_meta_reg <= 1'b0;
			en_sync_reg <= 1'b0;
		end else begin
			en_meta_reg <= shutdown_pin_n_in;
			en_sync_reg <= en_meta_reg;
		end
	end

	// Lockout and thermal faults, two flops
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			fault_meta_reg <= 2'h0;
			fault_sync_reg <= 2'h0;
		end else begin
			fault_meta_reg <= {uvlo_in, thermal_shutdown_pin_n_in};
			fault_sync_reg <= fault_meta_reg;
		end
	end

	// Overvoltage and zero crossing, two flops
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			prot_meta_reg <= 2'h0;
			prot_sync_reg <= 2'h0;
		end else begin
			prot_meta_reg <= {overvoltage_in, zero_cross_in};
			prot_sync_reg <= prot_meta_reg;
		end
	end

	// Phase 3 straps, two flops
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			strap_meta_reg <= 2'h0;
			strap_sync_reg <= 2'h0;
		end else begin
			strap_meta_reg <= {phase3_strap_off_in, reduced_phases_in};
			strap_sync_reg <= strap_meta_reg;
		end
	end

	// VID code, two flops, resets to the off code
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			vid_meta_reg <= VID_OFF_CODE;
			vid_reg <= VID_OFF_CODE;
		end else begin
			vid_meta_reg <= vid_code_inputs;
			vid_reg <= vid_meta_reg;
		end
	end

	// Synchronised levels by name
	assign pgood_s = pgood_sync_reg;
	assign en_s = en_sync_reg;
	assign {uvlo_s, therm_s} = fault_sync_reg;
	assign {ov_s, zc_s} = prot_sync_reg;
	assign {strap_s, redph_s} = strap_sync_reg;

	// ====================================================
	// Sequencer state
	crvs_state_t state_reg, state_next;
	logic [VID_W-1:0] level_reg;
	logic [7:0] slew_cnt_reg;
	logic vid_off, enabled, step, at_target, at_vid;
	logic [VID_W-1:0] target;
	logic [7:0] slew_div;

	// Off code and enable decoding
	assign vid_off = (vid_reg == VID_OFF_CODE);
	assign enabled = en_s && !vid_off && !uvlo_s && !therm_s;

	// Target level per state
	always_comb begin
		case (state_reg)
			CRVS_RUN: target = vid_reg;
			CRVS_SOFTSTART, CRVS_BOOT_HOLD, CRVS_FALLBACK: target = BOOT_LEVEL_DEF;
			default: target = DAC_ZERO;
		endcase
	end

	// Ramp timing
	assign at_target = (level_reg == target);
	assign at_vid = (level_reg == vid_reg);
	assign slew_div = slew_spacing(state_reg);
	assign step = (slew_cnt_reg >= slew_div - 8'h01);

	// Next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			CRVS_OFF: begin
				if (enabled) state_next = CRVS_SOFTSTART;
			end
			CRVS_SOFTSTART: begin
				if (at_target) state_next = CRVS_BOOT_HOLD;
			end
			CRVS_BOOT_HOLD: begin
				if (pgood_s) state_next = CRVS_RUN;
			end
			CRVS_RUN: begin
				if (!pgood_s) state_next = CRVS_FALLBACK;
			end
			CRVS_FALLBACK: begin
				if (pgood_s && at_target) state_next = CRVS_RUN;
			end
			CRVS_SOFTSTOP: begin
				if (at_target && enabled) state_next = CRVS_SOFTSTART;
			end
			default: begin
				state_next = CRVS_OFF;
			end
		endcase
		// Shutdown pin low or all-ones code share one soft-stop path
		if (!enabled && state_reg != CRVS_OFF && state_reg != CRVS_SOFTSTOP)
			state_next = CRVS_SOFTSTOP;
		if (state_reg == CRVS_SOFTSTOP && at_target && !enabled)
			state_next = CRVS_OFF;
	end

	// State register
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_reg <= CRVS_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// ====================================================
	// Slew ramp of the output target

	// Step spacing counter, idle at target
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			slew_cnt_reg <= 8'h00;
		end else if (at_target || step) begin
			slew_cnt_reg <= 8'h00;
		end else begin
			slew_cnt_reg <= slew_cnt_reg + 8'h01;
		end
	end

	// One step of the level per spacing period
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			level_reg <= DAC_ZERO;
		end else if (!at_target && step) begin
			level_reg <= step_toward(level_reg, target);
		end
	end

	// ====================================================
	// Status outputs
	logic shut, skip;
	assign shut = (state_reg == CRVS_OFF);
	assign skip = (state_reg == CRVS_FALLBACK) || (state_reg == CRVS_SOFTSTOP);

	// Clock enable only in regulated run, forced off at once on a fall
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cpu_clock_enable_n_out <= 1'b1;
		end else begin
			cpu_clock_enable_n_out <= !(state_next == CRVS_RUN);
		end
	end

	// Power-good once the level has reached the VID code
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			output_power_good_out <= 1'b0;
		end else begin
			output_power_good_out <= (state_next == CRVS_RUN) && at_vid;
		end
	end

	// Present ramp level
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			dac_level_out <= DAC_ZERO;
		end else begin
			dac_level_out <= level_reg;
		end
	end

	// Skip mode during fallback and soft stop
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			skip_mode_out <= 1'b0;
		end else begin
			skip_mode_out <= skip;
		end
	end

	// Discharge on lockout and thermal faults and once soft stop has ended
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			discharge_on_out <= 1'b0;
		end else begin
			discharge_on_out <= uvlo_s || therm_s || shut;
		end
	end

	// ====================================================
	// Driver forcing
	crvs_drive_t drv;

	// Gate levels from modulator requests and forcing conditions
	always_comb begin
		drv = '0;
		drv.high_side_gate1 = high_side_level(shut, pwm_req_in[0]);
		drv.high_side_gate2 = high_side_level(shut, pwm_req_in[1]);
		drv.low_side_gate1 = low_side_level(shut, ov_s, pwm_req_in[0], skip, zc_s);
		drv.low_side_gate2 = low_side_level(shut, ov_s, pwm_req_in[1], skip, zc_s);
		drv.skip_driver_ctl = !shut && skip;
		drv.phase3_pwm = phase3_pwm_out_req_in;
		drv.phase3_pwm_oe_n = shut || strap_s || redph_s;
	end

	// Registered gate drives, phase 3 floating in reset
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			drive_out <= '{default: 1'b0, phase3_pwm_oe_n: 1'b1};
		end else begin
			drive_out <= drv;
		end
	end

	// Boost switch follows the low-side gate of phase 1
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			boost_switch1_out <= 1'b0;
		end else begin
			boost_switch1_out <= drv.low_side_gate1;
		end
	end
endmodule : crvs_sequencer

// ===== crvs_pkg.sv
// Functional notes
// - After soft-start reaches boot level, hold boot, clock enable high, power-good low.
// - System power-good rising lets output follow VID and clock enable go low.
// - System power-good falling forces clock enable high and power-good low immediately.
// - Then ramp back to boot level in skip mode at quarter slew rate.
// - Hold boot level until off, power cycled, or system power-good returns.
// - Output target comes from the 7-bit VID code, always actively driven.
// - All-ones VID code starts soft shutdown identical to shutdown pin falling.
// - At zero volts drive gates and skip control low, float phase 3 PWM.
// - In VID shutdown the logic stays active and keeps watching VID inputs.
// - Leaving all-ones code runs start-up identical to shutdown pin rising.
// - Discharge transistor on for undervoltage lockout, thermal shutdown, soft shutdown end.
// - High-side gate 1 held low whenever in shutdown.
// - Phase 1 boost switch closed only while low-side gate 1 is high.
// - Low-side gates high on overvoltage; low in shutdown and after skip zero-cross.
// - Phase 3 PWM floats in shutdown, when strapped off, or with reduced phases.
package crvs_pkg;
	localparam int VID_W = 7;
	localparam logic [6:0] VID_OFF_CODE = 7'h7f;
	localparam logic [6:0] DAC_ZERO = 7'h00;
	// Boot target in VID units; arbitrary plain default
	localparam logic [6:0] BOOT_LEVEL_DEF = 7'h30;
	// Slew step spacing in cycles, normal and quarter rate
	localparam logic [7:0] SLEW_DIV_NORMAL = 8'h10;
	localparam logic [7:0] SLEW_DIV_QUARTER = 8'h40;
	typedef enum logic [2:0] {
		CRVS_OFF, CRVS_SOFTSTART, CRVS_BOOT_HOLD, CRVS_RUN, CRVS_FALLBACK, CRVS_SOFTSTOP
	} crvs_state_t;
	typedef struct packed {
		logic high_side_gate1;
		logic low_side_gate1;
		logic high_side_gate2;
		logic low_side_gate2;
		logic skip_driver_ctl;
		logic phase3_pwm;
		logic phase3_pwm_oe_n;
	} crvs_drive_t;
endpackage : crvs_pkg

// ===== crvs_sva.sv
`timescale 1ns/10ps
// =====
// Port checks
module crvs_sva
	import crvs_pkg::*;
(
	input wire logic sys_clk_in, // Clock
	input wire logic sys_rst_in, // Reset
	input wire logic system_power_good_in, // Rail good
	input wire logic [VID_W-1:0] vid_code_inputs, // VID
	input wire logic overvoltage_in, // Overvoltage
	input wire logic cpu_clock_enable_n_out, // Clock enable
	input wire logic output_power_good_out, // Power-good
	input wire logic [VID_W-1:0] dac_level_out, // Target
	input wire logic skip_mode_out, // Skip
	input wire crvs_drive_t drive_out, // Drives
	input wire logic boost_switch1_out, // Boost
	input wire logic discharge_on_out // Discharge
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	// Sequencing
	chk_pg_clk_en: assert property (output_power_good_out |-> !cpu_clock_enable_n_out)
		else $error("power-good with clock off");
	chk_low_pg_hold: assert property ((!system_power_good_in)[*4] |-> cpu_clock_enable_n_out)
		else $error("clock on while rail low");
	chk_pg_fall_react: assert property ($fell(system_power_good_in) |->
		##[1:4] (cpu_clock_enable_n_out && !output_power_good_out)) else $error("slow fall");
	chk_sync_hold: assert property ($rose(system_power_good_in) && cpu_clock_enable_n_out
		|=> cpu_clock_enable_n_out) else $error("unsynced rise");
	chk_off_code: assert property ((vid_code_inputs == VID_OFF_CODE)[*4] |->
		cpu_clock_enable_n_out && !output_power_good_out) else $error("off code ignored");
	chk_slow_slew: assert property (skip_mode_out[*2] ##0 $changed(dac_level_out)
		|=> $stable(dac_level_out)[*8]) else $error("fallback slew fast");
	// Drives
	chk_off_drives: assert property (discharge_on_out |-> !drive_out.high_side_gate1 &&
		!drive_out.low_side_gate1 && !drive_out.skip_driver_ctl && drive_out.phase3_pwm_oe_n)
		else $error("drive in off");
	chk_boost_ls: assert property (boost_switch1_out |-> drive_out.low_side_gate1)
		else $error("boost without low side");
	chk_ov_ls: assert property (overvoltage_in[*6] ##0 !cpu_clock_enable_n_out |->
		drive_out.low_side_gate1) else $error("low side not forced");
	cover property (output_power_good_out);
	cover property (skip_mode_out);
	cover property (discharge_on_out ##1 !discharge_on_out);
endmodule : crvs_sva

// ===== crvs_proc_model.sv
`timescale 1ns/10ps
// =====
// Processor side: VID and rail good, always driven
module crvs_proc_model (
	input wire logic clk_in, // Clock
	input wire logic [6:0] vid_cmd_in, // Wanted VID
	input wire logic pg_cmd_in, // Wanted rail good
	output logic [6:0] vid_out, // VID pins
	output logic pg_out // Rail good pin
);
	// Update just after edge
	always_ff @(posedge clk_in) begin
		vid_out <= vid_cmd_in;
		pg_out <= pg_cmd_in;
	end
endmodule : crvs_proc_model

// ===== tb_top.sv
`timescale 1ns/10ps
// =====
// Bench
module tb_top
	import crvs_pkg::*;
;
	logic clk = 0, rst = 1, pg_cmd = 0, shutdown_pin_n_n = 0, ov = 0, phase3_pwm_out = 0, pg_w, cen, pg, skip, bst, dis;
	logic [1:0] pwm = 0;
	logic [6:0] vid_cmd = 7'h7f, vid_w, dac;
	crvs_drive_t drv;
	int n_mismatch = 0, num_checks = 0, n;
	always #2 clk = ~clk;
	crvs_proc_model i_crvs_proc_model (.clk_in(clk), .vid_cmd_in(vid_cmd), .pg_cmd_in(pg_cmd),
		.vid_out(vid_w), .pg_out(pg_w));
	crvs_sequencer i_crvs_sequencer (.sys_clk_in(clk), .sys_rst_in(rst), .system_power_good_in(pg_w),
		.vid_code_inputs(vid_w), .shutdown_pin_n_in(shutdown_pin_n_n), .uvlo_in(1'b0), .thermal_shutdown_pin_n_in(1'b0),
		.overvoltage_in(ov), .zero_cross_in(1'b0), .phase3_strap_off_in(1'b0),
		.reduced_phases_in(1'b0), .pwm_req_in(pwm), .phase3_pwm_out_req_in(phase3_pwm_out),
		.cpu_clock_enable_n_out(cen), .output_power_good_out(pg), .dac_level_out(dac),
		.skip_mode_out(skip), .drive_out(drv), .boost_switch1_out(bst), .discharge_on_out(dis));
	task check(input string nm, input logic [6:0] seen, input logic [6:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : report_and_stop
	task wait_dac(input logic [6:0] v);
		for (n = 0; n < 3000 && dac !== v; n++) @(posedge clk);
		if (dac !== v) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask : wait_dac
	// Main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst <= 0;
		repeat (2) @(posedge clk);
		check("cen", 7'(cen), 7'h1);
		shutdown_pin_n_n <= 1;
		vid_cmd <= 7'h40;
		wait_dac(BOOT_LEVEL_DEF);
		repeat (20) @(posedge clk);
		check("cen", 7'(cen), 7'h1);
		check("boot", dac, BOOT_LEVEL_DEF);
		check("pg_boot", 7'(pg), 7'h0);
		pg_cmd <= 1;
		pwm <= 2'h3;
		wait_dac(7'h40);
		repeat (4) @(posedge clk);
		check("pgood", 7'(pg), 7'h1);
		check("cen_run", 7'(cen), 7'h0);
		check("oe_run", 7'(drv.phase3_pwm_oe_n), 7'h0);
		ov <= 1;
		repeat (8) @(posedge clk);
		check("ls1", 7'(drv.low_side_gate1), 7'h1);
		check("boost", 7'(bst), 7'h1);
		ov <= 0;
		pg_cmd <= 0;
		repeat (6) @(posedge clk);
		check("cen", 7'(cen), 7'h1);
		check("skip", 7'(skip), 7'h1);
		wait_dac(7'h3f);
		for (n = 0; n < 200 && dac !== 7'h3e; n++) @(posedge clk);
		check("step", 7'(n), 7'h40);
		wait_dac(BOOT_LEVEL_DEF);
		repeat (200) @(posedge clk);
		check("dac", dac, BOOT_LEVEL_DEF);
		pg_cmd <= 1;
		wait_dac(7'h40);
		repeat (4) @(posedge clk);
		check("pg_back", 7'(pg), 7'h1);
		pg_cmd <= 0;
		wait_dac(BOOT_LEVEL_DEF);
		vid_cmd <= VID_OFF_CODE;
		wait_dac(7'h00);
		repeat (8) @(posedge clk);
		check("dis", 7'(dis), 7'h1);
		check("hs1", 7'(drv.high_side_gate1), 7'h0);
		check("oe_n", 7'(drv.phase3_pwm_oe_n), 7'h1);
		check("skip_driver_ctl", 7'(drv.skip_driver_ctl), 7'h0);
		check("ls1_off", 7'(drv.low_side_gate1), 7'h0);
		vid_cmd <= 7'h20;
		wait_dac(BOOT_LEVEL_DEF);
		check("cen", 7'(cen), 7'h1);
		report_and_stop();
	end
endmodule : tb_top
bind crvs_sequencer crvs_sva i_crvs_sva (.*);
